// ---- rtl/lbus_regs.svh ----
// Constants for the multiplexed local bus master signalling block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef LBUS_REGS_SVH
`define LBUS_REGS_SVH
`define LB_WIDTH      32
`define LB_SIZE_LSB   0
`define LB_SIZE_MSB   1
`define LB_ADDR_LSB   2
`define LB_ADDR_MSB   31
`define LB_SIZE_1W    2'h0
`define LB_SIZE_2W    2'h1
`define LB_SIZE_3W    2'h2
`define LB_SIZE_4W    2'h3
`define LB_DATA_RST   32'h00000000
`define LB_DIV_RST    1'h0
`define LB_CNT_RST    2'h0
`define LB_CNT_ONE    2'h1
`endif

// ---- rtl/lbus_pkg.sv ----
// Types shared by the local bus master signalling block.
// Assumes lbus_regs.svh is on the include path.
`include "lbus_regs.svh"
package lbus_pkg;
   typedef enum logic [2:0] {
      IDLE_CYCLE,
      ADDR_CYCLE,
      XFER_CYCLE,
      WAIT_CYCLE,
      HOLD_CYCLE
   } bus_state_e;

   typedef struct packed {
      logic        write;
      logic        intack;
      logic [29:0] word_addr;
      logic [1:0]  size;
      logic [31:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic [31:0] o;
      logic        oe;
   } lad_drive_s;
endpackage

// ---- rtl/local_bus_master_signalling.sv ----
// Master-side sequencer of a multiplexed 32-bit local bus with burst support.
// Assumes mclk is the double-rate system clock and the pad ring resolves enables.
//
// Contract
// - Internal processor clock is the incoming double-rate clock divided by two.
// - Address cycle drives word address on bits 2-31, burst code on bits 0-1.
// - Burst code 00 one, 01 two, 10 three, 11 four words.
// - Data cycles carry 32-bit read data from agent or write data from device.
// - Shared lines float whenever not driving address or write data.
// - Address latch strobe asserted in address cycle, deasserted before data state.
// - Address latch strobe is active low and floats during hold cycles.
// - Address status strobe asserted each address cycle, deasserted in following data cycle.
// - In bursts, address status strobe re-asserts after a cycle with ready asserted.
// - Write/read indicated in address cycle, latched, held through all data cycles.
// - Direction line low for reads and interrupt acknowledges, high for writes.
// - Direction line never changes while transceiver enable is asserted.
// - Missing ready in a data cycle inserts a wait, withholding the status strobe.
// - Active-low transceiver enable asserted in every data and wait cycle.
`timescale 1ns/1ps
`default_nettype none
`include "lbus_regs.svh"
module local_bus_master_signalling
   import lbus_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        req_valid,
   input  wire bus_req_s    req,
   input  wire logic        next_wdata_valid,
   input  wire logic [31:0] next_wdata,
   input  wire logic        hold_req,
   input  wire logic        ready_n,
   input  wire logic [31:0] muxed_addr_data_i,
   output var  logic [31:0] muxed_addr_data_o,
   output var  logic        muxed_addr_data_oe,
   output var  logic        addr_latch_n_o,
   output var  logic        addr_latch_n_oe,
   output var  logic        addr_phase_strobe_n,
   output var  logic        write_read,
   output var  logic        transceiver_direction,
   output var  logic        transceiver_enable_n,
   output var  logic        hold_ack,
   output var  logic        req_ready,
   output var  logic        rdata_valid,
   output var  logic [31:0] rdata,
   output var  logic        proc_clk
);
   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   // Ready, hold and the shared lines arrive from outside and pass two flip-flops first.
   logic ready_s1_q, ready_s2_q, hold_s1_q, hold_s2_q;
   logic [31:0] lad_s1_q, lad_s2_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ready_s1_q <= 1'h1;
         ready_s2_q <= 1'h1;
         hold_s1_q  <= 1'h0;
         hold_s2_q  <= 1'h0;
         lad_s1_q   <= `LB_DATA_RST;
         lad_s2_q   <= `LB_DATA_RST;
      end else begin
         ready_s1_q <= ready_n;
         ready_s2_q <= ready_s1_q;
         hold_s1_q  <= hold_req;
         hold_s2_q  <= hold_s1_q;
         lad_s1_q   <= muxed_addr_data_i;
         lad_s2_q   <= lad_s1_q;
      end
   end
   wire logic ready_ok = !ready_s2_q;

   // ==========================================================================
   // Clock divider and bus sequencer
   // ==========================================================================
   // The bus advances once per internal processor clock, on the divider's phase.
   bus_state_e  state_q, state_d;
   logic        div_q, div_d;
   logic [1:0]  left_q, left_d;
   logic        wr_q, wr_d, ia_q, ia_d, rdy_prev_q, rdy_prev_d;
   logic [31:0] lad_q, lad_d, wbuf_q, wbuf_d, rdata_q, rdata_d;
   logic        lad_oe_q, lad_oe_d, ale_q, ale_d, ale_oe_q, ale_oe_d;
   logic        ads_q, ads_d, den_q, den_d, dtr_q, dtr_d, hlda_q, hlda_d;
   logic        rv_q, rv_d, acc_q, acc_d;

   always_comb begin
      div_d     = !div_q;
      state_d   = state_q;
      left_d    = left_q;
      wr_d      = wr_q;
      ia_d      = ia_q;
      rdy_prev_d = rdy_prev_q;
      wbuf_d    = wbuf_q;
      rdata_d   = rdata_q;
      rv_d      = 1'h0;
      acc_d     = 1'h0;
      if (next_wdata_valid) begin
         wbuf_d = next_wdata;
      end
      if (div_q) begin
         case (state_q)
            IDLE_CYCLE: begin
               if (hold_s2_q) begin
                  state_d = HOLD_CYCLE;
               end else if (req_valid) begin
                  state_d = ADDR_CYCLE;
                  left_d  = req.size;
                  wr_d    = req.write;
                  ia_d    = req.intack;
                  wbuf_d  = req.wdata;
                  acc_d   = 1'h1;
               end
            end
            ADDR_CYCLE: begin
               state_d    = XFER_CYCLE;
               rdy_prev_d = 1'h0;
            end
            XFER_CYCLE, WAIT_CYCLE: begin
               rdy_prev_d = ready_ok;
               if (ready_ok) begin
                  if (!wr_q) begin
                     rdata_d = lad_s2_q;
                     rv_d    = 1'h1;
                  end
                  if (left_q == `LB_CNT_RST) begin
                     state_d = IDLE_CYCLE;
                  end else begin
                     state_d = XFER_CYCLE;
                     left_d  = left_q - `LB_CNT_ONE;
                  end
               end else begin
                  state_d = WAIT_CYCLE;
               end
            end
            HOLD_CYCLE: begin
               if (!hold_s2_q) begin
                  state_d = IDLE_CYCLE;
               end
            end
            default: state_d = IDLE_CYCLE;
         endcase
      end
      // Pin values follow the next state so each pin is valid for its whole cycle.
      lad_d    = `LB_DATA_RST;
      lad_oe_d = 1'h0;
      ale_d    = 1'h1;
      ale_oe_d = (state_d != HOLD_CYCLE);
      ads_d    = 1'h1;
      den_d    = 1'h1;
      dtr_d    = dtr_q;
      hlda_d   = (state_d == HOLD_CYCLE);
      case (state_d)
         ADDR_CYCLE: begin
            lad_d    = {req.word_addr, req.size};
            lad_oe_d = 1'h1;
            // Low in the first half of the address cycle only, so it is high before data.
            ale_d    = !div_q;
            ads_d    = 1'h0;
            dtr_d    = wr_d && !ia_d;
         end
         XFER_CYCLE, WAIT_CYCLE: begin
            lad_d    = wr_q ? wbuf_d : `LB_DATA_RST;
            lad_oe_d = wr_q;
            den_d    = 1'h0;
            dtr_d    = dtr_q;
            // Every data cycle that follows an accepted word opens the next burst word.
            ads_d    = !(state_d == XFER_CYCLE && rdy_prev_d && state_q != ADDR_CYCLE);
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q    <= IDLE_CYCLE;
         div_q      <= `LB_DIV_RST;
         left_q     <= `LB_CNT_RST;
         wr_q       <= 1'h0;
         ia_q       <= 1'h0;
         rdy_prev_q <= 1'h0;
         wbuf_q     <= `LB_DATA_RST;
         rdata_q    <= `LB_DATA_RST;
         lad_q      <= `LB_DATA_RST;
         lad_oe_q   <= 1'h0;
         ale_q      <= 1'h1;
         ale_oe_q   <= 1'h1;
         ads_q      <= 1'h1;
         den_q      <= 1'h1;
         dtr_q      <= 1'h0;
         hlda_q     <= 1'h0;
         rv_q       <= 1'h0;
         acc_q      <= 1'h0;
      end else begin
         state_q    <= state_d;
         div_q      <= div_d;
         left_q     <= left_d;
         wr_q       <= wr_d;
         ia_q       <= ia_d;
         rdy_prev_q <= rdy_prev_d;
         wbuf_q     <= wbuf_d;
         rdata_q    <= rdata_d;
         lad_q      <= lad_d;
         lad_oe_q   <= lad_oe_d;
         ale_q      <= ale_d;
         ale_oe_q   <= ale_oe_d;
         ads_q      <= ads_d;
         den_q      <= den_d;
         dtr_q      <= dtr_d;
         hlda_q     <= hlda_d;
         rv_q       <= rv_d;
         acc_q      <= acc_d;
      end
   end

   assign muxed_addr_data_o     = lad_q;
   assign muxed_addr_data_oe    = lad_oe_q;
   assign addr_latch_n_o        = ale_q;
   assign addr_latch_n_oe       = ale_oe_q;
   assign addr_phase_strobe_n   = ads_q;
   assign write_read            = wr_q;
   assign transceiver_direction = dtr_q;
   assign transceiver_enable_n  = den_q;
   assign hold_ack              = hlda_q;
   assign req_ready             = acc_q;
   assign rdata_valid           = rv_q;
   assign rdata                 = rdata_q;
   assign proc_clk              = div_q;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   // Clock, idle and address cycles.
   AST_DIV: assert property (@(posedge mclk) disable iff (!resetn)
      $past(resetn) |-> proc_clk != $past(proc_clk))
      else $error("Divider did not toggle.");
   AST_ADDR: assert property (@(posedge mclk) disable iff (!resetn)
      (!addr_phase_strobe_n && state_q == ADDR_CYCLE) |-> muxed_addr_data_oe)
      else $error("Address not driven.");
   AST_ALE_ADDR: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == ADDR_CYCLE && $past(state_q) != ADDR_CYCLE) |-> !addr_latch_n_o)
      else $error("Latch strobe missing at address start.");
   AST_ALE_OFF: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == ADDR_CYCLE && $past(state_q) == ADDR_CYCLE) |-> addr_latch_n_o)
      else $error("Latch strobe still low before data.");
   AST_ADS_ADDR: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == ADDR_CYCLE) |-> !addr_phase_strobe_n)
      else $error("Status strobe missing in address cycle.");
   AST_ADS_FIRST: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == XFER_CYCLE && $past(state_q) == ADDR_CYCLE) |-> addr_phase_strobe_n)
      else $error("Status strobe held into first data cycle.");
   AST_ADS_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == IDLE_CYCLE && $past(state_q) == IDLE_CYCLE) |-> addr_phase_strobe_n)
      else $error("Status strobe while idle.");

   // Bus float, data and wait cycles.
   AST_FLOAT: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q inside {IDLE_CYCLE, HOLD_CYCLE}) && $past(state_q) == state_q
      |-> !muxed_addr_data_oe) else $error("Bus driven when idle.");
   AST_RDFLOAT: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == XFER_CYCLE && !wr_q && $past(state_q) == XFER_CYCLE)
      |-> !muxed_addr_data_oe) else $error("Bus driven during read.");
   AST_RDATA: assert property (@(posedge mclk) disable iff (!resetn)
      rdata_valid |-> !write_read)
      else $error("Read word delivered during a write.");
   AST_ALE_DATA: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == XFER_CYCLE && $past(state_q) == XFER_CYCLE) |-> addr_latch_n_o)
      else $error("Latch strobe in data state.");
   AST_DEN: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q inside {XFER_CYCLE, WAIT_CYCLE} && $past(state_q) == state_q)
      |-> !transceiver_enable_n) else $error("Enable missing in data.");
   AST_DTR: assert property (@(posedge mclk) disable iff (!resetn)
      (!transceiver_enable_n && !$past(transceiver_enable_n))
      |-> $stable(transceiver_direction)) else $error("Direction moved.");
   AST_WR: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q inside {XFER_CYCLE, WAIT_CYCLE}) |-> transceiver_direction == (wr_q && !ia_q))
      else $error("Direction disagrees with write.");
   AST_WR_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q inside {XFER_CYCLE, WAIT_CYCLE}) |-> $stable(write_read))
      else $error("Write indicator moved during data.");
   AST_WAIT: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == WAIT_CYCLE && $past(state_q) == WAIT_CYCLE) |-> addr_phase_strobe_n)
      else $error("Status strobe in wait.");
   AST_WAIT_ADS: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == WAIT_CYCLE) |-> addr_phase_strobe_n)
      else $error("Status strobe after a cycle without ready.");
   AST_ADS_BURST: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == XFER_CYCLE && $past(state_q) == WAIT_CYCLE) |-> !addr_phase_strobe_n)
      else $error("Status strobe missing after ready.");

   // Hold cycles.
   AST_ALE_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == HOLD_CYCLE && $past(state_q) == HOLD_CYCLE) |-> !addr_latch_n_oe)
      else $error("Latch strobe not floated in hold.");
   AST_HLDA: assert property (@(posedge mclk) disable iff (!resetn)
      hold_ack |-> (!addr_latch_n_oe && !muxed_addr_data_oe))
      else $error("Pins driven while hold is granted.");
   AST_REFUSE: assert property (@(posedge mclk) disable iff (!resetn)
      hold_ack |-> !req_ready)
      else $error("Request accepted during hold.");
endmodule // local_bus_master_signalling
`default_nettype wire

// ---- bench/lbus_agent.sv ----
// ==========================================
// Memory agent model on the far side of the local bus.
// Assumes registered enable and direction outputs from the master on mclk.
`timescale 1ns/1ps
`default_nettype none
module lbus_agent (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        transceiver_enable_n,
   input  wire logic        transceiver_direction,
   input  wire logic [3:0]  waits,
   input  wire logic [31:0] rd_base,
   output var  logic        ready_n,
   output var  logic [31:0] lad_i
);
   logic [4:0]  cnt;
   logic [31:0] word;
   logic [4:0]  lim;
   assign lim = {waits, 1'b0} + 5'h07;
   // Each word takes 2*waits+8 cycles; data is held well past the ready pulse.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt     <= 5'h00;
         word    <= 32'h00000000;
         ready_n <= 1'b1;
         lad_i   <= 32'hFFFFFFFF;
      end else if (transceiver_enable_n) begin
         cnt     <= 5'h00;
         word    <= rd_base;
         ready_n <= 1'b1;
         lad_i   <= ~lad_i;
      end else begin
         cnt     <= (cnt == lim) ? 5'h00 : cnt + 5'h01;
         word    <= (cnt == lim) ? word + 32'h00000001 : word;
         ready_n <= !(cnt == 5'h01 || cnt == 5'h02);
         lad_i   <= transceiver_direction ? ~lad_i : word;
      end
   end
endmodule // lbus_agent
`default_nettype wire

// ---- bench/tb_local_bus_master_signalling.sv ----
// ==========================================
// Self-checking bench for the local bus master signalling block.
// Assumes the design package is compiled first and lbus_agent is available.
`timescale 1ns/1ps
`default_nettype none
module tb_local_bus_master_signalling;
   import lbus_pkg::*;
   localparam logic [31:0] WD = 32'hA5C30F11;
   localparam logic [31:0] WN = 32'h5A3CF0EE;
   localparam logic [31:0] RB = 32'hC0DE0100;
   logic        mclk, resetn, req_valid, next_wdata_valid, hold_req, ready_n;
   bus_req_s    req;
   logic [31:0] next_wdata, lad_i, lad_o, rdata;
   logic        lad_oe, latch_n, latch_oe, ads_n, wr_rd, dir, den_n, hold_ack;
   logic        req_ready, rdata_valid, proc_clk, cur_wr, mon_on, p_clk, p_ads, p_rdy;
   logic [3:0]  waits;
   int          errors, checked, rd_cnt, rdy_cnt, ads_cnt;

   always #2 mclk = ~mclk;

   local_bus_master_signalling local_bus_master_signalling_inst (
      .mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req(req),
      .next_wdata_valid(next_wdata_valid), .next_wdata(next_wdata), .hold_req(hold_req),
      .ready_n(ready_n), .muxed_addr_data_i(lad_i), .muxed_addr_data_o(lad_o),
      .muxed_addr_data_oe(lad_oe), .addr_latch_n_o(latch_n), .addr_latch_n_oe(latch_oe),
      .addr_phase_strobe_n(ads_n), .write_read(wr_rd), .transceiver_direction(dir),
      .transceiver_enable_n(den_n), .hold_ack(hold_ack), .req_ready(req_ready),
      .rdata_valid(rdata_valid), .rdata(rdata), .proc_clk(proc_clk));

   lbus_agent lbus_agent_inst (
      .mclk(mclk), .resetn(resetn), .transceiver_enable_n(den_n),
      .transceiver_direction(dir), .waits(waits), .rd_base(RB),
      .ready_n(ready_n), .lad_i(lad_i));

   // ==========================================
   // Reporting
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========================================
   // Continuous pin monitor
   always @(negedge mclk) begin
      if (mon_on) begin
         check({31'h0, proc_clk}, {31'h0, ~p_clk});
         if (hold_ack === 1'b1) check({30'h0, lad_oe, latch_oe}, 32'h0);
         if (den_n === 1'b0) begin
            check({31'h0, dir}, {31'h0, cur_wr});
            check({31'h0, wr_rd}, {31'h0, cur_wr});
            check({31'h0, lad_oe}, {31'h0, cur_wr});
            if (cur_wr) check({31'h0, lad_o === WD || lad_o === WN}, 32'h1);
         end
         if (rdata_valid === 1'b1 && !cur_wr) begin
            check(rdata, RB + rd_cnt);
            rd_cnt++;
         end
         if (p_ads === 1'b1 && ads_n === 1'b0) ads_cnt++;
         if (p_rdy === 1'b1 && ready_n === 1'b0) rdy_cnt++;
      end
      p_clk = proc_clk;
      p_ads = ads_n;
      p_rdy = ready_n;
   end

   // ==========================================
   // Scenarios
   task automatic timeout();
      errors++;
      close_out();
   endtask

   task automatic do_xfer(input logic wr, input logic [1:0] sz, input logic [3:0] w);
      int n;
      waits = w;
      cur_wr = wr;
      rd_cnt = 0;
      rdy_cnt = 0;
      ads_cnt = 0;
      @(posedge mclk);
      #1;
      req = '{write: wr, intack: 1'b0, word_addr: 30'h2345670 + sz, size: sz, wdata: WD};
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (n > 40) timeout();
      end
      check(lad_o, {req.word_addr, sz});
      check({29'h0, lad_oe, latch_n, ads_n}, 32'h4);
      check({31'h0, wr_rd}, {31'h0, wr});
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      repeat (2) @(negedge mclk);
      check({29'h0, latch_n, ads_n, den_n}, 32'h6);
      n = 0;
      while (den_n !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (n > 400) timeout();
      end
      // The last read word shows at the same edge; let the monitor tally it first.
      @(posedge mclk);
      check(ads_cnt, sz + 1);
      check(rdy_cnt, sz + 1);
      if (!wr) check(rd_cnt, sz + 1);
   endtask

   task automatic hold_refusal();
      @(posedge mclk);
      #1;
      hold_req = 1'b1;
      repeat (8) @(negedge mclk);
      check({31'h0, hold_ack}, 32'h1);
      @(posedge mclk);
      #1;
      req_valid = 1'b1;
      repeat (12) begin
         @(negedge mclk);
         check({31'h0, req_ready}, 32'h0);
      end
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      hold_req = 1'b0;
      repeat (8) @(posedge mclk);
   endtask

   initial begin
      mclk = 0;
      resetn = 0;
      req_valid = 0;
      req = '0;
      next_wdata_valid = 1;
      next_wdata = WN;
      hold_req = 0;
      waits = 0;
      cur_wr = 0;
      mon_on = 0;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      check({28'h0, lad_oe, latch_oe, ads_n, den_n}, 32'h7);
      @(posedge mclk);
      #1;
      resetn = 1;
      repeat (4) @(posedge mclk);
      mon_on = 1;
      for (int s = 0; s < 4; s++) do_xfer(1'b0, s[1:0], 4'(s % 2 * 2));
      do_xfer(1'b1, 2'h3, 4'h1);
      do_xfer(1'b1, 2'h0, 4'h0);
      hold_refusal();
      do_xfer(1'b0, 2'h1, 4'h3);
      close_out();
   end
endmodule // tb_local_bus_master_signalling
`default_nettype wire
